/* rio_pkg.sv */
// Package of function codes, defaults and carriers for the remote I/O map
`default_nettype none

package rio_pkg;

    // ========================================================================
    // Input function codes
    localparam logic [5:0] RIO_IN_NONE     = 6'h00;
    localparam logic [5:0] RIO_IN_FWD      = 6'h01;
    localparam logic [5:0] RIO_IN_REV      = 6'h02;
    localparam logic [5:0] RIO_IN_HOME     = 6'h03;
    localparam logic [5:0] RIO_IN_START    = 6'h04;
    localparam logic [5:0] RIO_IN_SEQUENTIAL_START   = 6'h05;
    localparam logic [5:0] RIO_IN_INCHP    = 6'h06;
    localparam logic [5:0] RIO_IN_INCHM    = 6'h07;
    localparam logic [5:0] RIO_IN_DSEL0    = 6'h08;
    localparam logic [5:0] RIO_IN_FREE     = 6'h0E;
    localparam logic [5:0] RIO_IN_EXCITE   = 6'h0F;
    localparam logic [5:0] RIO_IN_STOP     = 6'h10;
    localparam logic [5:0] RIO_IN_ALMRST   = 6'h11;
    localparam logic [5:0] RIO_IN_PRESET   = 6'h12;
    localparam logic [5:0] RIO_IN_ABSRST   = 6'h13;
    localparam logic [5:0] RIO_IN_UNLOCK   = 6'h14;
    localparam logic [5:0] RIO_IN_GEN0     = 6'h15;
    localparam logic [5:0] RIO_IN_DATA0    = 6'h25;
    localparam int         RIO_IN_FUNCS    = 43;

    // ========================================================================
    // Output function codes; codes up to RIO_OUT_ECHO_LAST echo inputs
    localparam logic [5:0] RIO_OUT_NONE      = 6'h00;
    localparam logic [5:0] RIO_OUT_ECHO_LAST = 6'h2A;
    localparam logic [5:0] RIO_OUT_PLIM      = 6'h2B;
    localparam logic [5:0] RIO_OUT_MLIM      = 6'h2C;
    localparam logic [5:0] RIO_OUT_ORIGIN    = 6'h2D;
    localparam logic [5:0] RIO_OUT_SLIT      = 6'h2E;
    localparam logic [5:0] RIO_OUT_ALARM     = 6'h2F;
    localparam logic [5:0] RIO_OUT_WARN      = 6'h30;
    localparam logic [5:0] RIO_OUT_READY     = 6'h31;
    localparam logic [5:0] RIO_OUT_MOVE      = 6'h32;
    localparam logic [5:0] RIO_OUT_DONE      = 6'h33;
    localparam logic [5:0] RIO_OUT_INHOME    = 6'h34;
    localparam logic [5:0] RIO_OUT_TORQUE    = 6'h35;
    localparam logic [5:0] RIO_OUT_SHAFT     = 6'h36;
    localparam logic [5:0] RIO_OUT_ZONE1     = 6'h37;
    localparam logic [5:0] RIO_OUT_ZONE2     = 6'h38;
    localparam logic [5:0] RIO_OUT_ZONE3     = 6'h39;
    localparam logic [5:0] RIO_OUT_BUSY      = 6'h3A;
    localparam logic [5:0] RIO_OUT_MAINS     = 6'h3B;

    // ========================================================================
    // Default assignments, bit 15 first
    localparam logic [95:0] RIO_IN_DEFAULT = {
        RIO_IN_REV, RIO_IN_FWD, RIO_IN_INCHM, RIO_IN_INCHP,
        RIO_IN_SEQUENTIAL_START, 6'h0A, 6'h09, RIO_IN_DSEL0,
        RIO_IN_NONE, RIO_IN_FREE, RIO_IN_STOP, RIO_IN_HOME,
        RIO_IN_START, 6'h27, 6'h26, RIO_IN_DATA0};
    localparam logic [95:0] RIO_OUT_DEFAULT = {
        RIO_OUT_TORQUE, RIO_OUT_DONE, RIO_OUT_MOVE, RIO_OUT_SHAFT,
        RIO_OUT_ZONE3, RIO_OUT_ZONE2, RIO_OUT_ZONE1, RIO_OUT_BUSY,
        RIO_OUT_ALARM, RIO_OUT_WARN, RIO_OUT_READY, RIO_OUT_INHOME,
        RIO_IN_START, 6'h27, 6'h26, RIO_IN_DATA0};
    localparam logic [15:0] RIO_WORD_RESET = 16'h0000;
    localparam logic [15:0] RIO_LOW_MASK   = 16'h00FF;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic       forwardRun;
        logic       reverseRun;
        logic       homing;
        logic       posStart;
        logic       sequentialStart;
        logic       inchPlus;
        logic       inchMinus;
        logic [5:0] directSelect;
        logic       freeRun;
        logic       excite;
        logic       stop;
        logic       alarmResetPulse;
        logic       presetPulse;
        logic       absErrorResetPulse;
        logic       panelUnlock;
        logic [15:0] generalSignal;
        logic [5:0] dataSelect;
    } rio_cmd_t;

    typedef struct packed {
        logic       plusLimit;
        logic       minusLimit;
        logic       originSensor;
        logic       slitSensor;
        logic       alarmFlag;
        logic       warningFlag;
        logic       ready;
        logic       moving;
        logic       done;
        logic       inHome;
        logic       torqueLimitFlag;
        logic       shaftPulse;
        logic [2:0] zoneFlag;
        logic       internalBusy;
        logic       mainPowerOn;
    } rio_stat_t;

    typedef struct packed {
        logic [15:0] outWord;
        logic        alarmResetLast;
        logic        absResetLast;
        logic        presetLast;
        rio_cmd_t    cmd;
    } rio_state_t;

endpackage : rio_pkg

`default_nettype wire

/* rio_signal_map.sv */
// Remote I/O word to driver function map
`default_nettype none

// Behaviour
// [RULE1] Each of 16 input bits takes any input function by parameter
// [RULE2] Input assignment defaults to the documented layout after init
// [RULE3] Forward/reverse run continuously while 1, decelerate when 0
// [RULE4] Homing, start, sequential start, inch inputs start at 1
// [RULE5] Direct-select input starts positioning with its bound data number
// [RULE6] Six data select bits form operation data number 0 to 63
// [RULE7] Free-run at 1 de-energizes windings and releases brake
// [RULE8] Excitation input energizes at 1, de-energizes at 0
// [RULE9] Stop input at 1 stops operation
// [RULE10] Alarm and absolute-error resets act on falling edge only
// [RULE11] Preset acts on rising edge only
// [RULE12] Function on several bits is logical OR of those bits
// [RULE13] Unassigned excitation or panel-unlock is treated as 1
// [RULE14] Excitation or unlock on terminal and remote bit: logical AND
// [RULE15] Each of 16 output bits takes any status signal by parameter
// [RULE16] Output assignment defaults to the documented layout after init
// [RULE17] Echo outputs mirror input functions, sensors and general signals
// [RULE18] Alarm and warning outputs are 1 while present
// [RULE19] Ready, moving and done outputs reflect driver state
// [RULE20] In-home, torque-limit and zone outputs reflect position state
// [RULE21] Shaft pulse output passes the per-7.2 degree pulse
// [RULE22] Internal busy and main power outputs reflect their state
// [RULE23] Sixteen-axis mode exchanges only the lower eight bits
// [RULE24] Unassigned input bits ignored, unassigned output bits read 0
module rio_signal_map
    import rio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic        initDefaults,
    input  wire logic        sixteenAxisMode,
    input  wire logic [95:0] inAssign,
    input  wire logic [95:0] outAssign,
    input  wire logic [15:0] remoteInputWord,
    input  wire logic        termExcite,
    input  wire logic        termExciteAssigned,
    input  wire logic        termUnlock,
    input  wire logic        termUnlockAssigned,
    input  wire logic [35:0] directSelectData,
    input  wire rio_stat_t   status,
    output logic [95:0]      inAssignNow,
    output logic [95:0]      outAssignNow,
    output rio_cmd_t         cmd,
    output logic [5:0]       positionDataNumber,
    output logic             positionRequest,
    output logic [15:0]      remoteOutputWord
);

    // ========================================================================
    // Assignment tables
    logic [95:0] inTab;
    logic [95:0] outTab;
    logic [95:0] next_inTab;
    logic [95:0] next_outTab;

    // [RULE2] Input defaults after init
    // [RULE16] Output defaults after init
    always_comb begin
        next_inTab  = initDefaults ? RIO_IN_DEFAULT : inAssign;
        next_outTab = initDefaults ? RIO_OUT_DEFAULT : outAssign;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            inTab  <= RIO_IN_DEFAULT;
            outTab <= RIO_OUT_DEFAULT;
        end else if (clkEn) begin
            inTab  <= next_inTab;
            outTab <= next_outTab;
        end
    end

    assign inAssignNow  = inTab;
    assign outAssignNow = outTab;

    // ========================================================================
    // Helpers
    function automatic logic [5:0] code_of(input logic [95:0] tab,
                                           input int idx);
        code_of = tab[idx*6 +: 6];
    endfunction : code_of

    // [RULE12] OR of every bit carrying the code
    function automatic logic func_or(input logic [95:0] tab,
                                     input logic [15:0] word,
                                     input logic [5:0]  code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (code_of(tab, i) == code) begin
                r = r | word[i];
            end
        end
        func_or = r;
    endfunction : func_or

    function automatic logic func_used(input logic [95:0] tab,
                                       input logic [5:0]  code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (code_of(tab, i) == code) begin
                r = 1'b1;
            end
        end
        func_used = r;
    endfunction : func_used

    // ========================================================================
    // Input side
    rio_state_t  st;
    rio_state_t  next_st;
    logic [15:0] inWord;
    logic [RIO_IN_FUNCS-1:0] fnLevel;
    logic        exRemote;
    logic        ulRemote;
    logic        exUsed;
    logic        ulUsed;
    logic [15:0] outWordNext;
    logic [5:0]  oc;

    // [RULE23] Upper half dropped in sixteen-axis mode
    assign inWord = sixteenAxisMode ? (remoteInputWord & RIO_LOW_MASK)
                                    : remoteInputWord;

    // [RULE1] Per-bit function decode
    // [RULE24] Bits coded none never reach any function
    always_comb begin
        fnLevel = '0;
        for (int f = 1; f < RIO_IN_FUNCS; f++) begin
            fnLevel[f] = func_or(inTab, inWord, 6'(f));
        end
    end

    always_comb begin
        exRemote = fnLevel[RIO_IN_EXCITE];
        ulRemote = fnLevel[RIO_IN_UNLOCK];
        exUsed   = func_used(inTab, RIO_IN_EXCITE);
        ulUsed   = func_used(inTab, RIO_IN_UNLOCK);
    end

    always_comb begin
        next_st = st;
        // [RULE3] Continuous run levels
        next_st.cmd.forwardRun      = fnLevel[RIO_IN_FWD];
        next_st.cmd.reverseRun      = fnLevel[RIO_IN_REV];
        // [RULE4] Start levels
        next_st.cmd.homing          = fnLevel[RIO_IN_HOME];
        next_st.cmd.posStart        = fnLevel[RIO_IN_START];
        next_st.cmd.sequentialStart = fnLevel[RIO_IN_SEQUENTIAL_START];
        next_st.cmd.inchPlus        = fnLevel[RIO_IN_INCHP];
        next_st.cmd.inchMinus       = fnLevel[RIO_IN_INCHM];
        // [RULE5] Direct select
        next_st.cmd.directSelect    = fnLevel[13:8];
        // [RULE7] Free run
        next_st.cmd.freeRun         = fnLevel[RIO_IN_FREE];
        // [RULE9] Stop
        next_st.cmd.stop            = fnLevel[RIO_IN_STOP];
        // [RULE8] Excitation, [RULE13] default 1, [RULE14] AND of sources
        next_st.cmd.excite = (exUsed ? exRemote : 1'b1)
                           & (termExciteAssigned ? termExcite : 1'b1);
        next_st.cmd.panelUnlock = (ulUsed ? ulRemote : 1'b1)
                           & (termUnlockAssigned ? termUnlock : 1'b1);
        next_st.cmd.generalSignal   = fnLevel[36:21];
        // [RULE6] Data number bits
        next_st.cmd.dataSelect      = fnLevel[42:37];
        // [RULE10] Falling edge resets
        next_st.alarmResetLast = fnLevel[RIO_IN_ALMRST];
        next_st.absResetLast   = fnLevel[RIO_IN_ABSRST];
        next_st.cmd.alarmResetPulse =
            st.alarmResetLast & ~fnLevel[RIO_IN_ALMRST];
        next_st.cmd.absErrorResetPulse =
            st.absResetLast & ~fnLevel[RIO_IN_ABSRST];
        // [RULE11] Rising edge preset
        next_st.presetLast = fnLevel[RIO_IN_PRESET];
        next_st.cmd.presetPulse =
            ~st.presetLast & fnLevel[RIO_IN_PRESET];
        next_st.outWord = outWordNext;
    end

    // ========================================================================
    // Output side

    // [RULE15] Per-bit status select
    always_comb begin
        outWordNext = '0;
        oc = '0;
        for (int i = 0; i < 16; i++) begin
            oc = code_of(outTab, i);
            if (oc != RIO_OUT_NONE && oc <= RIO_OUT_ECHO_LAST) begin
                // [RULE17] Echo of decoded input function
                outWordNext[i] = fnLevel[oc];
            end else begin
                case (oc)
                    // [RULE17] Sensor echoes
                    RIO_OUT_PLIM:   outWordNext[i] = status.plusLimit;
                    RIO_OUT_MLIM:   outWordNext[i] = status.minusLimit;
                    RIO_OUT_ORIGIN: outWordNext[i] = status.originSensor;
                    RIO_OUT_SLIT:   outWordNext[i] = status.slitSensor;
                    // [RULE18] Alarm and warning
                    RIO_OUT_ALARM:  outWordNext[i] = status.alarmFlag;
                    RIO_OUT_WARN:   outWordNext[i] = status.warningFlag;
                    // [RULE19] Ready, moving, done
                    RIO_OUT_READY:  outWordNext[i] = status.ready;
                    RIO_OUT_MOVE:   outWordNext[i] = status.moving;
                    RIO_OUT_DONE:   outWordNext[i] = status.done;
                    // [RULE20] Home, torque, zones
                    RIO_OUT_INHOME: outWordNext[i] = status.inHome;
                    RIO_OUT_TORQUE: outWordNext[i] = status.torqueLimitFlag;
                    RIO_OUT_ZONE1:  outWordNext[i] = status.zoneFlag[0];
                    RIO_OUT_ZONE2:  outWordNext[i] = status.zoneFlag[1];
                    RIO_OUT_ZONE3:  outWordNext[i] = status.zoneFlag[2];
                    // [RULE21] Shaft pulse
                    RIO_OUT_SHAFT:  outWordNext[i] = status.shaftPulse;
                    // [RULE22] Busy and mains
                    RIO_OUT_BUSY:   outWordNext[i] = status.internalBusy;
                    RIO_OUT_MAINS:  outWordNext[i] = status.mainPowerOn;
                    // [RULE24] Unassigned reads 0
                    default:        outWordNext[i] = 1'b0;
                endcase
            end
        end
        // [RULE23] Lower eight bits only in sixteen-axis mode
        if (sixteenAxisMode) begin
            outWordNext = outWordNext & RIO_LOW_MASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{outWord: RIO_WORD_RESET, alarmResetLast: 1'b0,
                    absResetLast: 1'b0, presetLast: 1'b0, cmd: '0};
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Positioning request: direct select wins over data select
    logic [5:0] dirNum;

    // [RULE5] Bound number of lowest active direct select
    // [RULE6] Else the data select number
    always_comb begin
        dirNum = '0;
        for (int k = 5; k >= 0; k--) begin
            if (st.cmd.directSelect[k]) begin
                dirNum = directSelectData[k*6 +: 6];
            end
        end
    end

    assign cmd                = st.cmd;
    assign positionRequest    = st.cmd.posStart | (|st.cmd.directSelect);
    assign positionDataNumber = (|st.cmd.directSelect) ? dirNum
                                                       : st.cmd.dataSelect;
    assign remoteOutputWord   = st.outWord;

endmodule : rio_signal_map

`default_nettype wire

/* rio_conv_model.sv */
// Network converter model that sends the remote input word
`default_nettype none

module rio_conv_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sixteenAxisMode,
    input  wire logic [15:0] sendWord,
    output logic [15:0]      remoteInputWord
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] stale;

    // ========================================================================
    // Upper byte
    // Not carried in eight-bit mode, so it shows changing junk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stale <= 8'h5A;
        end else begin
            stale <= ~stale;
        end
    end

    assign remoteInputWord = sixteenAxisMode ? {stale, sendWord[7:0]}
                                             : sendWord;
endmodule : rio_conv_model

`default_nettype wire

/* rio_signal_map_checker.sv */
// Port assertions for the remote I/O signal map
`default_nettype none

module rio_signal_map_checker
    import rio_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        clkEn,
    input wire logic        initDefaults,
    input wire logic        sixteenAxisMode,
    input wire logic        termExcite,
    input wire logic        termExciteAssigned,
    input wire logic [35:0] directSelectData,
    input wire logic [95:0] inAssignNow,
    input wire logic [95:0] outAssignNow,
    input wire rio_cmd_t    cmd,
    input wire logic [5:0]  positionDataNumber,
    input wire logic        positionRequest,
    input wire logic [15:0] remoteOutputWord
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ========================================================================
    // Command side
    // request source
    AST_POS_REQ: assert property (
        positionRequest == (cmd.posStart || (|cmd.directSelect)))
        else $error("position request mismatch");
    AST_DATA_NUM: assert property (
        cmd.posStart && cmd.directSelect == 6'h00
        |-> positionDataNumber == cmd.dataSelect)
        else $error("data number not from data select");
    AST_DIRECT: assert property (
        cmd.directSelect[0] |-> positionDataNumber == directSelectData[5:0])
        else $error("direct select number mismatch");
    AST_ALM_PULSE: assert property (
        cmd.alarmResetPulse && clkEn |=> $fell(cmd.alarmResetPulse))
        else $error("alarm reset pulse too long");
    AST_EXCITE_AND: assert property (
        clkEn && termExciteAssigned && !termExcite |=> !cmd.excite)
        else $error("excite set with terminal low");
    AST_INIT_DEF: assert property (
        initDefaults && clkEn |=> inAssignNow == RIO_IN_DEFAULT
        && outAssignNow == RIO_OUT_DEFAULT)
        else $error("default tables not loaded");

    // ========================================================================
    // Status side
    // upper byte masked
    AST_MASK_OUT: assert property (
        clkEn && sixteenAxisMode |=> remoteOutputWord[15:8] == 8'h00)
        else $error("upper output byte driven in eight-bit mode");
    AST_OUT_NONE: assert property (
        clkEn && outAssignNow == '0 |-> ##1 remoteOutputWord == 16'h0000)
        else $error("unassigned output bit set");
endmodule : rio_signal_map_checker

bind rio_signal_map rio_signal_map_checker rio_signal_map_checker_inst (
    .clk, .rstn, .clkEn, .initDefaults, .sixteenAxisMode, .termExcite,
    .termExciteAssigned, .directSelectData, .inAssignNow, .outAssignNow,
    .cmd, .positionDataNumber, .positionRequest, .remoteOutputWord);

`default_nettype wire

/* tb.sv */
// Self-checking bench for the remote I/O signal map
`default_nettype none

module tb
    import rio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [95:0] EXP_IN = {RIO_IN_REV, RIO_IN_FWD, RIO_IN_INCHM,
        RIO_IN_INCHP, RIO_IN_SEQUENTIAL_START, RIO_IN_DSEL0 + 6'h02,
        RIO_IN_DSEL0 + 6'h01, RIO_IN_DSEL0, RIO_IN_NONE, RIO_IN_FREE,
        RIO_IN_STOP, RIO_IN_HOME, RIO_IN_START, RIO_IN_DATA0 + 6'h02,
        RIO_IN_DATA0 + 6'h01, RIO_IN_DATA0};
    localparam logic [95:0] EXP_OUT = {RIO_OUT_TORQUE, RIO_OUT_DONE,
        RIO_OUT_MOVE, RIO_OUT_SHAFT, RIO_OUT_ZONE3, RIO_OUT_ZONE2,
        RIO_OUT_ZONE1, RIO_OUT_BUSY, RIO_OUT_ALARM, RIO_OUT_WARN,
        RIO_OUT_READY, RIO_OUT_INHOME, RIO_IN_START, RIO_IN_DATA0 + 6'h02,
        RIO_IN_DATA0 + 6'h01, RIO_IN_DATA0};
    localparam logic [95:0] CUST_IN = {RIO_IN_DSEL0 + 6'h05, RIO_IN_NONE,
        RIO_IN_GEN0 + 6'h03, RIO_IN_UNLOCK, RIO_IN_ABSRST, RIO_IN_PRESET,
        RIO_IN_ALMRST, RIO_IN_EXCITE, RIO_IN_START, RIO_IN_START,
        RIO_IN_DATA0 + 6'h05, RIO_IN_DATA0 + 6'h04, RIO_IN_DATA0 + 6'h03,
        RIO_IN_DATA0 + 6'h02, RIO_IN_DATA0 + 6'h01, RIO_IN_DATA0};

    logic        clk, rstn, clkEn, initDefaults, sixteenAxisMode;
    logic        termExcite, termExciteAssigned, termUnlock;
    logic        termUnlockAssigned, positionRequest;
    logic [95:0] inAssign, outAssign, inAssignNow, outAssignNow;
    logic [15:0] sendWord, remoteInputWord, remoteOutputWord;
    logic [35:0] directSelectData;
    logic [5:0]  positionDataNumber;
    rio_stat_t   status;
    rio_cmd_t    cmd, base;
    int          n_errors, compares;

    rio_conv_model rio_conv_model_inst (.clk, .rstn, .sixteenAxisMode,
        .sendWord, .remoteInputWord);
    rio_signal_map rio_signal_map_inst (.clk, .rstn, .clkEn,
        .initDefaults, .sixteenAxisMode, .inAssign, .outAssign,
        .remoteInputWord, .termExcite, .termExciteAssigned, .termUnlock,
        .termUnlockAssigned, .directSelectData, .status, .inAssignNow,
        .outAssignNow, .cmd, .positionDataNumber, .positionRequest,
        .remoteOutputWord);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic step(input int n = 1);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // ========================================================================
    // Scenarios
    task automatic check_defaults();
        inAssign = '0;
        outAssign = '0;
        initDefaults = 1'b1;
        step();
        chk(inAssignNow, EXP_IN);
        chk(outAssignNow, EXP_OUT);
        initDefaults = 1'b0;
        inAssign = EXP_IN;
        outAssign = EXP_OUT;
    endtask : check_defaults

    task automatic check_inputs();
        rio_cmd_t e;
        int       k;
        for (int i = 0; i < 16; i++) begin
            sendWord = 16'h0001 << i;
            step();
            e = base;
            case (i)
                0, 1, 2: e.dataSelect[i] = 1'b1;
                3: e.posStart = 1'b1;
                4: e.homing = 1'b1;
                5: e.stop = 1'b1;
                6: e.freeRun = 1'b1;
                8, 9, 10: e.directSelect[i - 8] = 1'b1;
                11: e.sequentialStart = 1'b1;
                12: e.inchPlus = 1'b1;
                13: e.inchMinus = 1'b1;
                14: e.forwardRun = 1'b1;
                15: e.reverseRun = 1'b1;
                default: e = base;
            endcase
            chk(cmd, e);
            chk(positionRequest, i == 3 || (i >= 8 && i <= 10));
            if (i >= 8 && i <= 10) begin
                k = 6 * (i - 8);
                chk(positionDataNumber, directSelectData[k +: 6]);
            end
        end
    endtask : check_inputs

    task automatic check_custom();
        rio_cmd_t e;
        inAssign = CUST_IN;
        step();
        sendWord = 16'h007F;
        step();
        e = '0;
        e.posStart = 1'b1;
        e.dataSelect = 6'h3F;
        chk(cmd, e);
        chk(positionDataNumber, 6'h3F);
        sendWord = 16'h0080;
        step();
        e.dataSelect = 6'h00;
        chk(cmd, e);
        sendWord = 16'hE000;
        step();
        e = '0;
        e.directSelect[5] = 1'b1;
        e.generalSignal[3] = 1'b1;
        chk(cmd, e);
        chk(positionDataNumber, directSelectData[35:30]);
        sendWord = 16'h0A00;
        step();
        chk({cmd.alarmResetPulse, cmd.absErrorResetPulse}, 2'b00);
        sendWord = 16'h0400;
        step();
        chk({cmd.alarmResetPulse, cmd.absErrorResetPulse}, 2'b11);
        chk(cmd.presetPulse, 1'b1);
        step();
        chk({cmd.alarmResetPulse, cmd.presetPulse}, 2'b00);
        termExciteAssigned = 1'b1;
        termUnlockAssigned = 1'b1;
        termExcite = 1'b1;
        sendWord = 16'h1100;
        step();
        chk({cmd.excite, cmd.panelUnlock}, 2'b10);
        termExcite = 1'b0;
        termUnlock = 1'b1;
        step();
        chk({cmd.excite, cmd.panelUnlock}, 2'b01);
        termExcite = 1'b1;
        sendWord = 16'h0000;
        step();
        chk({cmd.excite, cmd.panelUnlock}, 2'b00);
        termExciteAssigned = 1'b0;
        termUnlockAssigned = 1'b0;
        inAssign = EXP_IN;
        step();
    endtask : check_custom

    task automatic check_outputs();
        int idx;
        status = '1;
        sendWord = 16'h000F;
        step();
        chk(remoteOutputWord, 16'hFFFF);
        status = '0;
        sendWord = 16'h0005;
        step();
        chk(remoteOutputWord, 16'h0005);
        for (int j = 0; j < 16; j++) begin
            outAssign[6 * j +: 6] = RIO_OUT_PLIM + 6'(j);
        end
        step();
        for (int j = 0; j < 16; j++) begin
            idx = j < 12 ? 16 - j : (j < 15 ? j - 10 : 1);
            status = rio_stat_t'(17'h0_0001 << idx);
            step();
            chk(remoteOutputWord, 16'h0001 << j);
        end
        outAssign = '0;
        status = '1;
        step(2);
        chk(remoteOutputWord, 16'h0000);
        outAssign = 96'(RIO_OUT_MAINS);
        step(2);
        chk(remoteOutputWord, 16'h0001);
        outAssign = EXP_OUT;
        step();
    endtask : check_outputs

    task automatic check_mode();
        rio_cmd_t e;
        e = base;
        e.dataSelect = 6'h07;
        e.posStart = 1'b1;
        e.homing = 1'b1;
        e.stop = 1'b1;
        e.freeRun = 1'b1;
        sixteenAxisMode = 1'b1;
        sendWord = 16'hFFFF;
        for (int k = 0; k < 3; k++) begin
            step();
            chk(cmd, e);
            chk(remoteOutputWord, 16'h00FF);
        end
        // Frozen enable holds every output
        clkEn = 1'b0;
        sendWord = 16'h0000;
        step(2);
        chk(cmd, e);
        chk(remoteOutputWord, 16'h00FF);
        clkEn = 1'b1;
        step();
        chk(cmd, base);
        sixteenAxisMode = 1'b0;
    endtask : check_mode

    initial begin
        {n_errors, compares} = '0;
        {rstn, initDefaults, sixteenAxisMode, termExcite} = '0;
        clkEn = 1'b1;
        {termExciteAssigned, termUnlock, termUnlockAssigned} = '0;
        inAssign = EXP_IN;
        outAssign = EXP_OUT;
        sendWord = 16'h0000;
        directSelectData = 36'h9_8765_4321;
        status = '0;
        base = '0;
        base.excite = 1'b1;
        base.panelUnlock = 1'b1;
        step(16);
        rstn = 1'b1;
        step();
        check_defaults();
        check_inputs();
        check_custom();
        check_outputs();
        check_mode();
        summarize();
    end
endmodule : tb

`default_nettype wire
